// ### logic/msvu_core.sv
// Memory space, stack pointer and vector unit of the core, with AXI4-Lite registers.
// Assumes requests and command strobes come from the core sequencer on aclk.
//
// Operation
// - Program and data are separate 64K spaces, each with 16-bit addresses.
// - Program addresses 0 to 1FFFh are served by the internal ROM.
// - Fetches above the first 8K bytes become external bus cycles.
// - Program/data select output accompanies external accesses.
// - Space set by select-data or select-program command, held until changed.
// - External stack accesses always go to data space.
// - Memory-to-memory transfers take both spaces from the instruction encoding.
// - Opcodes and immediate operands always come from program space.
// - Once data space is selected, operand and stack references use data space.
// - Operand address is direct, register-pair indirect, or base plus byte/word offset.
// - Vector even byte is PC high half, odd byte is PC low half.
// - Bytes 0-1 reset vector, 2-3 divide trap vector, 4-5 top-level vector.
// - Vector table in first 256 bytes; software base, hardware channel bits.
// - Peripheral supplies its vector through its vector select register.
// - Divide trap does not push flags; it behaves like a subroutine call.
// - Accepted interrupts are taken only after the current instruction completes.
// - Eight external interrupt channels, each with selectable trigger edge.
// - Top-level channel is assignable to the NMI pin or the timer watchdog.
// - User stack pointer is two bytes; register-file stacks use only the low byte.
// - System stack pointer is high byte at EEh and low byte at EFh.
// - Romless option disables the ROM; all program accesses go external.
// - Push pre-decrements the stack pointer; pop reads then post-increments.
// - Mode bits pick internal or external stack per stack; reset selects internal.
// - External stack address: even pointer byte high, odd pointer byte low.
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "msvu_defs.svh"

module msvu_core
  import msvu_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Core sequencer side
  input wire msvu_req_s req,
  input wire logic cmd_sel_data,
  input wire logic cmd_sel_prog,
  input wire logic instr_done,
  input wire logic div_zero_trap,
  input wire logic vec_data_valid,
  input wire logic [7:0] vec_even_byte,
  input wire logic [7:0] vec_odd_byte,
  // Interrupt sources and strap
  input wire logic [7:0] ext_int,
  input wire logic nmi_pin,
  input wire logic watchdog_event,
  input wire logic romless_strap,
  // Resolved outputs
  output msvu_acc_s acc,
  output logic prog_data_sel,
  output msvu_vec_s vec,
  output logic pc_load_valid,
  output logic [15:0] pc_load
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  logic [7:0] core_mode_register;
  logic [7:0] user_stack_ptr_high;
  logic [7:0] user_stack_ptr_low;
  logic [7:0] system_stack_ptr_high;
  logic [7:0] system_stack_ptr_low;
  logic [7:0] vector_select_register;
  logic [7:0] edge_sel;
  logic [7:0] int_enable;
  logic [7:0] pending;
  logic [7:0] ext_prev;
  logic top_from_nmi;
  logic top_pend;
  logic nmi_prev;
  logic data_space;
  logic romless;
  logic strap_done;
  logic boot;
  logic aw_held;
  logic w_held;
  logic [9:0] aw_idx;
  logic [7:0] w_byte;
  logic w_en;

  // ------------------------------------------------------------
  // Bus handshake decode
  // ------------------------------------------------------------
  // Address and data are latched independently, so either may arrive first.
  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take = s_axi_wvalid & s_axi_wready;
  wire aw_have = aw_held | aw_take;
  wire w_have = w_held | w_take;
  wire wr_fire = aw_held & w_held & ~s_axi_bvalid;
  wire next_aw_held = aw_held ? ~wr_fire : aw_take;
  wire next_w_held = w_held ? ~wr_fire : w_take;
  wire next_bvalid = s_axi_bvalid ? ~s_axi_bready : wr_fire;
  wire ar_take = s_axi_arvalid & s_axi_arready;
  wire next_rvalid = s_axi_rvalid ? ~s_axi_rready : ar_take;
  wire [9:0] ar_idx = s_axi_araddr[11:2];
  wire wr_is_known = (aw_idx[9:8] == 2'b00) && (aw_idx[7:0] >= `MSVU_IDX_MODE) && (aw_idx[7:0] <= `MSVU_IDX_ENA);
  wire rd_is_known = (ar_idx[9:8] == 2'b00) && (ar_idx[7:0] >= `MSVU_IDX_MODE) && (ar_idx[7:0] <= `MSVU_IDX_ENA);
  wire wr_ok = wr_fire & wr_is_known & w_en;
  wire [7:0] wr_reg = aw_idx[7:0];
  wire wr_mode = wr_ok && (wr_reg == `MSVU_IDX_MODE);
  wire wr_usph = wr_ok && (wr_reg == `MSVU_IDX_USP_HI);
  wire wr_uspl = wr_ok && (wr_reg == `MSVU_IDX_USP_LO);
  wire wr_ssph = wr_ok && (wr_reg == `MSVU_IDX_SSP_HI);
  wire wr_sspl = wr_ok && (wr_reg == `MSVU_IDX_SSP_LO);
  wire wr_space = wr_ok && (wr_reg == `MSVU_IDX_SPACE);
  wire wr_vsel = wr_ok && (wr_reg == `MSVU_IDX_VSEL);
  wire wr_edge = wr_ok && (wr_reg == `MSVU_IDX_EDGE);
  wire wr_pend = wr_ok && (wr_reg == `MSVU_IDX_PEND);
  wire wr_cfg = wr_ok && (wr_reg == `MSVU_IDX_CFG);
  wire wr_ena = wr_ok && (wr_reg == `MSVU_IDX_ENA);

  // Bus channel flops; ready is registered, so a take drops it for the next cycle.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `MSVU_RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      aw_idx <= 10'h000;
      w_byte <= 8'h00;
      w_en <= 1'b0;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      s_axi_awready <= ~next_aw_held & ~(aw_have & ~wr_fire);
      s_axi_wready <= ~next_w_held & ~(w_have & ~wr_fire);
      s_axi_bvalid <= next_bvalid;
      s_axi_arready <= ~next_rvalid;
      s_axi_rvalid <= next_rvalid;
      if (aw_take) begin
        aw_idx <= s_axi_awaddr[11:2];
      end
      if (w_take) begin
        w_byte <= s_axi_wdata[7:0];
        w_en <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        s_axi_bresp <= wr_is_known ? `MSVU_RESP_OKAY : `MSVU_RESP_SLVERR;
      end
    end
  end

  // ------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------
  logic [7:0] rd_byte;
  always_comb begin
    case (ar_idx[7:0])
      `MSVU_IDX_MODE: rd_byte = core_mode_register;
      `MSVU_IDX_USP_HI: rd_byte = user_stack_ptr_high;
      `MSVU_IDX_USP_LO: rd_byte = user_stack_ptr_low;
      `MSVU_IDX_SSP_HI: rd_byte = system_stack_ptr_high;
      `MSVU_IDX_SSP_LO: rd_byte = system_stack_ptr_low;
      `MSVU_IDX_SPACE: rd_byte = {6'h00, romless, data_space};
      `MSVU_IDX_VSEL: rd_byte = vector_select_register;
      `MSVU_IDX_EDGE: rd_byte = edge_sel;
      `MSVU_IDX_PEND: rd_byte = pending;
      `MSVU_IDX_CFG: rd_byte = {6'h00, top_pend, top_from_nmi};
      `MSVU_IDX_ENA: rd_byte = int_enable;
      default: rd_byte = 8'h00;
    endcase
  end

  // Read answer is captured at the address take; unknown indices read zero with SLVERR.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `MSVU_RESP_OKAY;
    end else if (ar_take) begin
      s_axi_rdata <= {24'h00_0000, rd_is_known ? rd_byte : 8'h00};
      s_axi_rresp <= rd_is_known ? `MSVU_RESP_OKAY : `MSVU_RESP_SLVERR;
    end
  end

  // ------------------------------------------------------------
  // Address formation and space steering
  // ------------------------------------------------------------
  wire is_stack = req.valid && (req.kind == MSVU_K_STACK);
  wire stk_internal = req.user ? core_mode_register[`MSVU_MODE_USP_INT] : core_mode_register[`MSVU_MODE_SSP_INT];
  wire [15:0] stk_ptr = req.user ? {user_stack_ptr_high, user_stack_ptr_low}
                                 : {system_stack_ptr_high, system_stack_ptr_low};
  wire [15:0] stk_dec = stk_ptr - 16'h0001;
  wire [15:0] stk_inc = stk_ptr + 16'h0001;
  wire [7:0] stk_dec_lo = stk_ptr[7:0] - 8'h01;
  wire [7:0] stk_inc_lo = stk_ptr[7:0] + 8'h01;
  wire [15:0] stk_addr = req.push ? stk_dec : stk_ptr;
  wire [7:0] stk_reg = req.push ? stk_dec_lo : stk_ptr[7:0];
  wire [15:0] stk_next = stk_internal ? {stk_ptr[15:8], req.push ? stk_dec_lo : stk_inc_lo}
                                      : (req.push ? stk_dec : stk_inc);

  logic [15:0] oper_addr;
  always_comb begin
    case (req.amode)
      MSVU_A_DIRECT: oper_addr = req.addr;
      MSVU_A_PAIR: oper_addr = req.base;
      MSVU_A_IDXB: oper_addr = req.base + {8'h00, req.offset[7:0]};
      MSVU_A_IDXW: oper_addr = req.base + req.offset;
      default: oper_addr = req.addr;
    endcase
  end

  // Program-space decision per access kind; the latched select only reaches plain operands.
  logic in_prog;
  logic [15:0] acc_addr;
  always_comb begin
    in_prog = 1'b1;
    acc_addr = oper_addr;
    case (req.kind)
      MSVU_K_FETCH: begin
        in_prog = 1'b1;
        acc_addr = req.addr;
      end
      MSVU_K_IMM: begin
        in_prog = 1'b1;
        acc_addr = req.addr;
      end
      MSVU_K_OPER: in_prog = ~data_space;
      MSVU_K_STACK: begin
        in_prog = 1'b0;
        acc_addr = stk_addr;
      end
      MSVU_K_XSRC: in_prog = ~req.xfer[1];
      MSVU_K_XDST: in_prog = ~req.xfer[0];
      default: in_prog = 1'b1;
    endcase
  end

  wire to_regfile = is_stack & stk_internal;
  wire in_rom = in_prog & ~to_regfile & (acc_addr <= `MSVU_ROM_TOP) & ~romless;
  wire go_external = req.valid & ~to_regfile & ~in_rom;

  // Registered access toward the memory interface, one cycle after the request.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc <= '0;
      prog_data_sel <= 1'b1;
    end else begin
      acc.valid <= req.valid;
      acc.addr <= acc_addr;
      acc.prog_space <= in_prog & ~to_regfile;
      acc.internal_rom <= req.valid & in_rom;
      acc.external <= go_external;
      acc.regfile <= req.valid & to_regfile;
      acc.reg_addr <= stk_reg;
      if (go_external) begin
        prog_data_sel <= in_prog;
      end
    end
  end

  // ------------------------------------------------------------
  // Mode, space select, strap and stack pointers
  // ------------------------------------------------------------
  // The strap is caught once after reset release, never under the reset itself.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      core_mode_register <= `MSVU_MODE_RESET;
      data_space <= 1'b0;
      romless <= 1'b0;
      strap_done <= 1'b0;
      vector_select_register <= `MSVU_VSEL_RESET;
      edge_sel <= 8'h00;
      int_enable <= 8'h00;
      top_from_nmi <= 1'b1;
    end else begin
      if (!strap_done) begin
        romless <= romless_strap;
        strap_done <= 1'b1;
      end
      if (wr_mode) core_mode_register <= w_byte;
      if (cmd_sel_data) data_space <= 1'b1;
      else if (cmd_sel_prog) data_space <= 1'b0;
      else if (wr_space) data_space <= w_byte[0];
      if (wr_vsel) vector_select_register <= w_byte;
      if (wr_edge) edge_sel <= w_byte;
      if (wr_ena) int_enable <= w_byte;
      if (wr_cfg) top_from_nmi <= w_byte[`MSVU_CFG_TOP_NMI];
    end
  end

  // Pointer bytes: a stack operation in the same cycle wins over a bus write.
  wire stk_u = is_stack & req.user;
  wire stk_s = is_stack & ~req.user;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      user_stack_ptr_high <= 8'h00;
      user_stack_ptr_low <= 8'h00;
      system_stack_ptr_high <= 8'h00;
      system_stack_ptr_low <= 8'h00;
    end else begin
      if (stk_u) {user_stack_ptr_high, user_stack_ptr_low} <= stk_next;
      else begin
        if (wr_usph) user_stack_ptr_high <= w_byte;
        if (wr_uspl) user_stack_ptr_low <= w_byte;
      end
      if (stk_s) {system_stack_ptr_high, system_stack_ptr_low} <= stk_next;
      else begin
        if (wr_ssph) system_stack_ptr_high <= w_byte;
        if (wr_sspl) system_stack_ptr_low <= w_byte;
      end
    end
  end

  // ------------------------------------------------------------
  // External channels and top-level source
  // ------------------------------------------------------------
  logic [2:0] take_ch;
  logic any_ch;
  always_comb begin
    take_ch = 3'h0;
    any_ch = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      if (pending[i] & int_enable[i]) begin
        take_ch = 3'(i);
        any_ch = 1'b1;
      end
    end
  end

  wire take_top = instr_done & top_pend & ~div_zero_trap & ~boot;
  wire take_ch_now = instr_done & any_ch & ~top_pend & ~div_zero_trap & ~boot;

  // One pending flop per channel; a new edge in the clearing cycle keeps the bit set.
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_chan
      wire hit = edge_sel[g] ? (ext_int[g] & ~ext_prev[g]) : (~ext_int[g] & ext_prev[g]);
      wire clr = (wr_pend & w_byte[g]) | (take_ch_now && (take_ch == 3'(g)));
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          pending[g] <= 1'b0;
          ext_prev[g] <= 1'b0;
        end else begin
          ext_prev[g] <= ext_int[g];
          pending[g] <= hit | (pending[g] & ~clr);
        end
      end
    end
  endgenerate

  wire top_hit = top_from_nmi ? (nmi_pin & ~nmi_prev) : watchdog_event;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      nmi_prev <= 1'b0;
      top_pend <= 1'b0;
    end else begin
      nmi_prev <= nmi_pin;
      top_pend <= top_hit | (top_pend & ~take_top);
    end
  end

  // ------------------------------------------------------------
  // Vector location and program counter load
  // ------------------------------------------------------------
  // Channel bits replace bits 3:1 of the software base; the table stays below 100h.
  wire [15:0] periph_vec = {8'h00, vector_select_register[7:4], take_ch, 1'b0};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      boot <= 1'b1;
      vec <= '0;
      pc_load_valid <= 1'b0;
      pc_load <= 16'h0000;
    end else begin
      boot <= 1'b0;
      vec.valid <= boot | div_zero_trap | take_top | take_ch_now;
      vec.push_flags <= ~boot & ~div_zero_trap & (take_top | take_ch_now);
      if (boot) vec.addr <= `MSVU_VEC_RESET;
      else if (div_zero_trap) vec.addr <= `MSVU_VEC_TRAP;
      else if (take_top) vec.addr <= `MSVU_VEC_TOP;
      else if (take_ch_now) vec.addr <= periph_vec;
      pc_load_valid <= vec_data_valid;
      if (vec_data_valid) pc_load <= {vec_even_byte, vec_odd_byte};
    end
  end

endmodule : msvu_core
`default_nettype wire

// ### logic/msvu_defs.svh
// Constants for the memory space, stack and vector unit.
// Assumes inclusion by bare name from the package and the core module.
`ifndef MSVU_DEFS_SVH
`define MSVU_DEFS_SVH

// ------------------------------------------------------------
// Register indices; byte address is four times the index
// ------------------------------------------------------------
`define MSVU_IDX_MODE 8'heb
`define MSVU_IDX_USP_HI 8'hec
`define MSVU_IDX_USP_LO 8'hed
`define MSVU_IDX_SSP_HI 8'hee
`define MSVU_IDX_SSP_LO 8'hef
`define MSVU_IDX_SPACE 8'hf0
`define MSVU_IDX_VSEL 8'hf1
`define MSVU_IDX_EDGE 8'hf2
`define MSVU_IDX_PEND 8'hf3
`define MSVU_IDX_CFG 8'hf4
`define MSVU_IDX_ENA 8'hf5

// ------------------------------------------------------------
// Field positions and reset values
// ------------------------------------------------------------
`define MSVU_MODE_RESET 8'he0
`define MSVU_MODE_SSP_INT 7
`define MSVU_MODE_USP_INT 6
`define MSVU_VSEL_RESET 8'h00
`define MSVU_CFG_TOP_NMI 0

// ------------------------------------------------------------
// Memory map and vector locations
// ------------------------------------------------------------
`define MSVU_ROM_TOP 16'h1fff
`define MSVU_VEC_RESET 16'h0000
`define MSVU_VEC_TRAP 16'h0002
`define MSVU_VEC_TOP 16'h0004
`define MSVU_RESP_OKAY 2'b00
`define MSVU_RESP_SLVERR 2'b10

`endif

// ### logic/msvu_pkg.sv
// Types shared by the memory space, stack and vector unit.
// Assumes the constants header is on the include path.
`include "msvu_defs.svh"

package msvu_pkg;

  // ------------------------------------------------------------
  // Access kinds and operand address forms
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    MSVU_K_FETCH = 3'h0,
    MSVU_K_IMM = 3'h1,
    MSVU_K_OPER = 3'h2,
    MSVU_K_STACK = 3'h3,
    MSVU_K_XSRC = 3'h4,
    MSVU_K_XDST = 3'h5
  } msvu_kind_e;

  typedef enum logic [1:0] {
    MSVU_A_DIRECT = 2'h0,
    MSVU_A_PAIR = 2'h1,
    MSVU_A_IDXB = 2'h2,
    MSVU_A_IDXW = 2'h3
  } msvu_amode_e;

  // Access request from the core's instruction sequencer.
  typedef struct packed {
    logic valid;
    msvu_kind_e kind;
    msvu_amode_e amode;
    logic [15:0] addr;
    logic [15:0] base;
    logic [15:0] offset;
    logic [1:0] xfer;
    logic user;
    logic push;
  } msvu_req_s;

  // Resolved access toward the memory interface.
  typedef struct packed {
    logic valid;
    logic [15:0] addr;
    logic prog_space;
    logic internal_rom;
    logic external;
    logic regfile;
    logic [7:0] reg_addr;
  } msvu_acc_s;

  // Vector location handed to the sequencer.
  typedef struct packed {
    logic valid;
    logic [15:0] addr;
    logic push_flags;
  } msvu_vec_s;

endpackage : msvu_pkg

// ### tb/msvu_ext_mem.sv
// External program memory model answering vector fetches.
// Assumes vector locations arrive as one-cycle pulses on aclk.
`timescale 1ns/100ps
`default_nettype none

module msvu_ext_mem
  import msvu_pkg::*;
(
  // Clock
  input wire logic aclk,
  // Vector fetch and answer
  input wire msvu_vec_s vec,
  output logic vec_data_valid,
  output logic [7:0] vec_even_byte,
  output logic [7:0] vec_odd_byte
);
  // ------------------------------------------------------------
  // Vector bytes
  // ------------------------------------------------------------
  initial {vec_data_valid, vec_even_byte, vec_odd_byte} = '0;

  // Bytes are the address folded with 5Ah; idle bytes flip so stale data shows.
  always @(posedge aclk) begin
    vec_data_valid <= vec.valid;
    if (vec.valid) begin
      vec_even_byte <= {vec.addr[7:1], 1'b0} ^ 8'h5a;
      vec_odd_byte <= {vec.addr[7:1], 1'b1} ^ 8'h5a;
    end else begin
      vec_even_byte <= ~vec_even_byte;
      vec_odd_byte <= ~vec_odd_byte;
    end
  end
endmodule : msvu_ext_mem
`default_nettype wire

// ### tb/msvu_checker.sv
// Port assertions for the memory space, stack and vector unit.
// Assumes the strap only changes while reset is held.
`timescale 1ns/100ps
`default_nettype none

module msvu_checker
  import msvu_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Sequencer side
  input wire msvu_req_s req,
  input wire logic instr_done,
  input wire logic div_zero_trap,
  input wire logic vec_data_valid,
  input wire logic [7:0] vec_even_byte,
  input wire logic [7:0] vec_odd_byte,
  input wire logic romless_strap,
  // Resolved outputs
  input wire msvu_acc_s acc,
  input wire logic prog_data_sel,
  input wire msvu_vec_s vec,
  input wire logic pc_load_valid,
  input wire logic [15:0] pc_load
);
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Outputs are registered, so checks look one cycle on.
  rom_map_a: assert property (req.valid && req.kind == MSVU_K_FETCH && !romless_strap
    |=> acc.internal_rom == ($past(req.addr) <= 16'h1fff)) else $error("ROM map wrong");
  romless_a: assert property (req.valid && req.kind == MSVU_K_FETCH && romless_strap
    |=> acc.external && !acc.internal_rom) else $error("Romless fetch not external");
  fetch_prog_a: assert property (req.valid && (req.kind == MSVU_K_FETCH || req.kind == MSVU_K_IMM)
    |=> acc.valid && acc.prog_space) else $error("Fetch not in program space");
  stack_data_a: assert property (req.valid && req.kind == MSVU_K_STACK
    |=> acc.regfile || !acc.prog_space) else $error("External stack not in data space");
  xfer_space_a: assert property (req.valid && req.kind == MSVU_K_XSRC
    |=> acc.prog_space == !$past(req.xfer[1])) else $error("Transfer source space wrong");
  sel_pin_a: assert property (acc.valid && acc.external |-> prog_data_sel == acc.prog_space)
    else $error("Space pin wrong");
  pc_load_a: assert property (vec_data_valid |=> pc_load_valid
    && pc_load == $past({vec_even_byte, vec_odd_byte})) else $error("PC load wrong");
  trap_vec_a: assert property (div_zero_trap |=> vec.valid && vec.addr == 16'h0002
    && !vec.push_flags) else $error("Trap vector wrong");
  vec_table_a: assert property (vec.valid |-> vec.addr[15:8] == 8'h00 && !vec.addr[0])
    else $error("Vector outside table");
  int_done_a: assert property (vec.valid && vec.push_flags |-> $past(instr_done))
    else $error("Interrupt taken mid-instruction");

  cover property (vec.valid && vec.push_flags);
  cover property (acc.valid && acc.regfile);
  cover property (pc_load_valid);
endmodule : msvu_checker

bind msvu_core msvu_checker u_chk (.*);
`default_nettype wire

// ### tb/test_msvu_core.sv
// Self-checking bench for the memory space, stack and vector unit.
// Assumes the package, partner model and checker are compiled first.
`timescale 1ns/100ps
`default_nettype none
`include "msvu_defs.svh"

module test_msvu_core;
  import msvu_pkg::*;
  logic aclk, aresetn, romless_strap, nmi_pin, prog_data_sel, pc_load_valid, vec_data_valid;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic cmd_sel_data, cmd_sel_prog, instr_done, div_zero_trap, watchdog_event;
  logic [7:0] vec_even_byte, vec_odd_byte, ext_int;
  logic [15:0] pc_load;
  logic [4:0] pz;
  msvu_req_s req;
  msvu_acc_s acc;
  msvu_vec_s vec;
  int fail_count = 0, comparisons = 0;
  logic [7:0] pv [4] = '{8'h77, 8'hd0, 8'h12, 8'h34};

  // Pulse lines share one vector for one pulse task.
  assign {watchdog_event, div_zero_trap, cmd_sel_prog, cmd_sel_data, instr_done} = pz;

  msvu_core uut (.*);
  msvu_ext_mem mem (.*);

  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er = `MSVU_RESP_OKAY);
    logic ad = 1'b0, wd = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge aclk);
      ad = ad | s_axi_awready;
      wd = wd | s_axi_wready;
      s_axi_awvalid <= !ad;
      s_axi_wvalid <= !wd;
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, er);
  endtask : wr

  task rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er = `MSVU_RESP_OKAY);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, ed);
    chk(s_axi_rresp, er);
  endtask : rd

  // One request; returns with acc settled.
  task go(input msvu_kind_e k, input logic [15:0] a, input msvu_amode_e m = MSVU_A_DIRECT,
      input logic [1:0] x = 2'b00, input logic u = 1'b0, input logic p = 1'b0);
    @(posedge aclk);
    req <= '{1'b1, k, m, a, 16'h1000, 16'h01ff, x, u, p};
    @(posedge aclk);
    req.valid <= 1'b0;
    #1;
  endtask : go

  task ca(input logic [15:0] ea, input logic [4:0] ef);
    chk(acc.addr, ea);
    chk({acc.valid, acc.prog_space, acc.internal_rom, acc.external, acc.regfile}, ef);
  endtask : ca

  task pulse(input int b);
    @(posedge aclk);
    pz[b] <= 1'b1;
    @(posedge aclk);
    pz[b] <= 1'b0;
  endtask : pulse

  task vw(input logic [15:0] ea, input logic ep);
    #1;
    for (int i = 0; i < 8 && vec.valid !== 1'b1; i++) @(posedge aclk) #1;
    chk({vec.valid, vec.addr, vec.push_flags}, {1'b1, ea, ep});
  endtask : vw

  task rst(input logic rl);
    @(posedge aclk);
    aresetn <= 1'b0;
    romless_strap <= rl;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    vw(16'h0000, 1'b0);
  endtask : rst

  task te(input string s);
    $display("Test %s finished", s);
  endtask : te

  task end_of_test;
    $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_of_test

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, req, pz, nmi_pin} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    ext_int = 8'h20;
    rst(1'b0);
    rd(12'h3ac, 32'he0);
    rd(12'h3fc, 32'h0, `MSVU_RESP_SLVERR);
    wr(12'h3fc, 32'h5, `MSVU_RESP_SLVERR);
    for (int i = 0; i < 4; i++) wr(12'h3b0 + 12'(4 * i), {24'h0, pv[i]});
    for (int i = 0; i < 4; i++) rd(12'h3b0 + 12'(4 * i), {24'h0, pv[i]});
    te("registers");
    go(MSVU_K_FETCH, 16'h1fff);
    ca(16'h1fff, 5'b11100);
    go(MSVU_K_FETCH, 16'h2000);
    ca(16'h2000, 5'b11010);
    pulse(1);
    chk(prog_data_sel, 1'b1);
    go(MSVU_K_OPER, 16'h1234);
    ca(16'h1234, 5'b10010);
    go(MSVU_K_IMM, 16'h0100);
    ca(16'h0100, 5'b11100);
    go(MSVU_K_OPER, 16'hffff, MSVU_A_IDXB);
    ca(16'h10ff, 5'b10010);
    go(MSVU_K_OPER, 16'hffff, MSVU_A_IDXW);
    ca(16'h11ff, 5'b10010);
    go(MSVU_K_OPER, 16'h4321, MSVU_A_PAIR);
    ca(16'h1000, 5'b10010);
    for (int i = 0; i < 4; i++) begin
      go(MSVU_K_XSRC, 16'h3000, MSVU_A_DIRECT, 2'(i));
      ca(16'h3000, {1'b1, ~i[1], 3'b010});
      go(MSVU_K_XDST, 16'h3000, MSVU_A_DIRECT, 2'(i));
      ca(16'h3000, {1'b1, ~i[0], 3'b010});
    end
    pulse(2);
    go(MSVU_K_OPER, 16'h0500);
    ca(16'h0500, 5'b11100);
    te("spaces");
    go(MSVU_K_STACK, 16'h0, MSVU_A_DIRECT, 2'b00, 1'b1, 1'b1);
    chk({acc.valid, acc.regfile, acc.reg_addr}, {2'b11, 8'hcf});
    rd(12'h3b4, 32'hcf);
    rd(12'h3b0, 32'h77);
    wr(12'h3ac, 32'h00);
    go(MSVU_K_STACK, 16'h0, MSVU_A_DIRECT, 2'b00, 1'b0, 1'b1);
    ca(16'h1233, 5'b10010);
    go(MSVU_K_STACK, 16'h0, MSVU_A_DIRECT, 2'b00, 1'b0, 1'b0);
    ca(16'h1233, 5'b10010);
    rd(12'h3bc, 32'h34);
    chk(prog_data_sel, 1'b0);
    te("stacks");
    pulse(3);
    vw(16'h0002, 1'b0);
    repeat (2) @(posedge aclk);
    #1;
    chk({pc_load_valid, pc_load}, {1'b1, 16'h5859});
    wr(12'h3c4, 32'ha0);
    wr(12'h3c8, 32'h04);
    wr(12'h3d4, 32'h24);
    ext_int <= 8'h24;
    repeat (3) @(posedge aclk);
    #1;
    chk(vec.valid, 1'b0);
    pulse(0);
    vw(16'h00a4, 1'b1);
    ext_int <= 8'h04;
    pulse(0);
    vw(16'h00aa, 1'b1);
    nmi_pin <= 1'b1;
    pulse(0);
    vw(16'h0004, 1'b1);
    wr(12'h3d0, 32'h0);
    pulse(4);
    pulse(0);
    vw(16'h0004, 1'b1);
    te("vectors");
    rst(1'b1);
    go(MSVU_K_FETCH, 16'h0100);
    ca(16'h0100, 5'b11010);
    te("romless");
    end_of_test();
  end

  // Hang guard; the tests need about 150 cycles.
  initial begin
    repeat (3000) @(posedge aclk);
    fail_count++;
    end_of_test();
  end
endmodule : test_msvu_core
`default_nettype wire
